//--- include/modbus_pkg.sv
// Purpose: shared constants and types for the modbus/tcp function-code handler
// Assumes: byte-wide frame streams holding the mbap header followed by the pdu
// Notes:   byte offsets count from the first mbap byte of a frame
package modbus_pkg;
  // transport
  localparam logic [15:0] TCP_PORT      = 16'h01F6; // port 502
  localparam logic [15:0] PROTO_ID      = 16'h0000;
  // function codes
  localparam logic [7:0]  FC_READ_COILS = 8'h01;
  localparam logic [7:0]  FC_READ_INPUTS = 8'h02;
  localparam logic [7:0]  FC_READ_HOLD  = 8'h03;
  localparam logic [7:0]  FC_READ_INREG = 8'h04;
  localparam logic [7:0]  FC_FORCE_ONE  = 8'h05;
  localparam logic [7:0]  FC_PRESET_ONE = 8'h06;
  localparam logic [7:0]  FC_READ_EXC   = 8'h07;
  localparam logic [7:0]  FC_FORCE_MULT = 8'h0F;
  localparam logic [7:0]  FC_PRESET_MULT = 8'h10;
  localparam logic [7:0]  FC_RAW        = 8'hFF; // minus one
  // exception answers
  localparam logic [7:0]  EXC_FLAG      = 8'h80;
  localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
  localparam logic [7:0]  EXC_ILL_VAL   = 8'h03;
  // accepted ranges
  localparam logic [15:0] COIL_MAX_ADDR = 16'h0017;
  localparam logic [15:0] COIL_MAX_QTY  = 16'h0018;
  localparam logic [15:0] REG_MAX_QTY   = 16'h0010;
  localparam logic [15:0] WORD_MAX_ADDR = 16'h0001;
  localparam logic [15:0] COIL_ON       = 16'hFF00;
  localparam logic [15:0] COIL_OFF      = 16'h0000;
  // sizes
  localparam int          NUM_DIO       = 24;
  localparam int          NUM_AN        = 8;
  localparam int          BUF_DEPTH     = 48;
  localparam int          MAX_RAW_WORDS = 2;
  // frame byte offsets and lengths
  localparam int          OFS_LEN_LO    = 5;
  localparam int          OFS_UNIT      = 6;
  localparam int          OFS_FC        = 7;
  localparam int          OFS_BC        = 8;
  localparam int          OFS_WDATA     = 13;
  localparam logic [5:0]  MIN_FRAME     = 6'h08;
  localparam logic [5:0]  ECHO_PDU      = 6'h05;
  localparam logic [5:0]  SHORT_PDU     = 6'h02;
  // values after reset
  localparam logic [23:0] DOUT_RST      = 24'h000000;
  localparam logic [31:0] AOUT_RST      = 32'h00000000;
  localparam logic [15:0] TID_RST       = 16'h0000;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_EXEC, S_TX, S_RAW} st_t;
endpackage

//--- include/coil_pack_if.sv
// Purpose: carries a coil/input packing request and its answer between modules
// Assumes: purely combinational exchange inside one clock domain
// Notes:   qty is the requested bit count, count the status byte count
`timescale 1ns/1ps
`default_nettype none
interface coil_pack_if;
  logic [23:0] src;
  logic [4:0]  start;
  logic [4:0]  qty;
  logic [23:0] packed_bits;
  logic [1:0]  count;
  modport packer (input src, input start, input qty, output packed_bits, output count);
  modport user   (output src, output start, output qty, input packed_bits, input count);
endinterface
`default_nettype wire

//--- logic/coil_packer.sv
// Purpose: packs a window of coil or input states into status bytes
// Assumes: caller has range checked start and qty
// Notes:   bits past the last coil read as zero
`timescale 1ns/1ps
`default_nettype none
module coil_packer
  import modbus_pkg::*;
(
  // packing request and answer
  coil_pack_if.packer pk
);
  logic [5:0] qty_ext;

  //////////////////////////////////////////////////////////////////////////////
  // byte count rounds the bit count up to whole bytes
  assign qty_ext  = {1'b0, pk.qty};
  assign pk.count = 2'(qty_ext >> 3) + 2'((qty_ext[2:0] != 3'h0) ? 1 : 0); // see [R10]

  //////////////////////////////////////////////////////////////////////////////
  // bit i of the stream is coil start+i, lowest address in bit zero
  for (genvar i = 0; i < NUM_DIO; i++) begin : g_bit
    logic [5:0] pos;
    assign pos = 6'(pk.start) + 6'(i);
    assign pk.packed_bits[i] = (6'(i) < qty_ext && pos < 6'(NUM_DIO)) ?
                               pk.src[pos[4:0]] : 1'b0; // see [R11] see [R12]
  end
endmodule
`default_nettype wire

//--- logic/modbus_tcp_coil_responder.sv
// Purpose: modbus/tcp function-code handler, slave answers and master packet build
// Assumes: tcp stack delivers whole frames (mbap + pdu) with their local port
// Notes:   one frame at a time; the answer is staged fully before it streams
// Functional notes
// [R1] modbus frames travel as binary payload of tcp packets on byte streams
// [R2] all modbus traffic uses tcp port 502 only
// [R3] function codes 1,2,3,4,5,6,7,15,16 are recognised
// [R4] every code works both as master request and slave answer
// [R5] master code minus one sends the caller's raw packet untouched
// [R6] code 3 reads analog inputs, code 4 analog outputs; swap exchanges them
// [R7] read coils returns the digital output states
// [R8] coil reads accept start 0 to 0x17 and quantity 1 to 0x18
// [R9] read coils answer is code 01 then a status byte count
// [R10] byte count is quantity over eight, plus one on a remainder
// [R11] bit zero of first byte is the start address, then ascending
// [R12] coil n maps straight onto digital output n, 0 to 23
// [R13] multi-output writes pack eight outputs per byte, first byte outputs 7-0
// [R14] a 32-bit analog value fills two consecutive 16-bit registers
// [R15] code 2 reads digital inputs with the coil ranges and packing
// [R16] codes 5,6,15 write digital outputs, 7 reads them, 16 writes analog
// [R17] out-of-range requests are rejected with no output change
`timescale 1ns/1ps
`default_nettype none
module modbus_tcp_coil_responder
  import modbus_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // role and configuration
  input  wire logic                  master_mode,
  input  wire logic                  analog_code_swap_setting,
  // frames from the tcp stack
  input  wire logic                  rx_valid,
  input  wire logic [7:0]            rx_data,
  input  wire logic                  rx_last,
  input  wire logic [15:0]           rx_port,
  output logic                       rx_ready,
  // frames to the tcp stack
  output logic                       tx_valid,
  output logic [7:0]                 tx_data,
  output logic                       tx_last,
  output logic [15:0]                tx_port,
  input  wire logic                  tx_ready,
  // master packet build command
  input  wire logic                  packet_build_command,
  input  wire logic [7:0]            cmd_fc,
  input  wire logic [7:0]            cmd_unit,
  input  wire logic [15:0]           cmd_addr,
  input  wire logic [15:0]           cmd_qty,
  input  wire logic [31:0]           cmd_value,
  output logic                       cmd_ready,
  // master raw packet bytes
  input  wire logic                  raw_valid,
  input  wire logic [7:0]            raw_data,
  input  wire logic                  raw_last,
  output logic                       raw_ready,
  // master: answers from the remote slave
  output logic                       rsp_valid,
  output logic [7:0]                 rsp_data,
  output logic                       rsp_last,
  // i/o
  input  wire logic [NUM_DIO-1:0]    din_pin,
  output logic [NUM_DIO-1:0]         dout,
  input  wire logic [NUM_AN*32-1:0]  ain,
  output logic [NUM_AN*32-1:0]       aout
);
  typedef struct packed {
    st_t                            st;
    logic [5:0]                     idx;
    logic [5:0]                     rx_cnt;
    logic                           drop;
    logic [BUF_DEPTH-1:0][7:0]      rxb;
    logic [BUF_DEPTH-1:0][7:0]      txb;
    logic [5:0]                     tx_len;
    logic                           tv;
    logic [7:0]                     tbyte;
    logic                           tlast;
    logic [15:0]                    tid;
    logic [NUM_DIO-1:0]             dout;
    logic [NUM_AN-1:0][31:0]        aout;
    logic [NUM_DIO-1:0]             s1;
    logic [NUM_DIO-1:0]             s2;
    logic [NUM_DIO-1:0]             s3;
    logic [NUM_DIO-1:0]             dstb;
    logic                           rsp_v;
    logic [7:0]                     rsp_b;
    logic                           rsp_l;
  } state_t;

  state_t                  st;
  state_t                  next_st;
  coil_pack_if             pk ();
  logic [7:0]              fc;
  logic [15:0]             addr;
  logic [15:0]             qty;
  logic                    range_ok;
  logic [NUM_AN-1:0][31:0] rd_src;

  coil_packer u_pack (
    .pk (pk)
  );

  //////////////////////////////////////////////////////////////////////////////
  // request fields and packer feed
  assign fc       = st.rxb[OFS_FC];
  assign addr     = {st.rxb[8], st.rxb[9]};
  assign qty      = {st.rxb[10], st.rxb[11]};
  assign pk.src   = (fc == FC_READ_INPUTS) ? st.dstb : st.dout; // see [R7] see [R15]
  assign pk.start = addr[4:0];
  assign pk.qty   = qty[4:0];
  // code 3 reads inputs unless swapped, code 4 the other set
  assign rd_src   = ((fc == FC_READ_HOLD) ^ analog_code_swap_setting) ?
                    ain : st.aout; // see [R6]

  //////////////////////////////////////////////////////////////////////////////
  // ports; readies are combinational, valids and data come from flops
  assign rx_ready  = (st.st == S_IDLE) || (st.st == S_RX);
  assign cmd_ready = (st.st == S_IDLE) && master_mode;
  assign raw_ready = (st.st == S_RAW) && !st.tv;
  assign tx_valid  = st.tv;
  assign tx_data   = st.tbyte;
  assign tx_last   = st.tlast;
  assign tx_port   = TCP_PORT; // see [R2]
  assign rsp_valid = st.rsp_v;
  assign rsp_data  = st.rsp_b;
  assign rsp_last  = st.rsp_l;
  assign dout      = st.dout;
  assign aout      = st.aout;

  //////////////////////////////////////////////////////////////////////////////
  // next state: sync, receive, decode, build, stream
  always_comb begin
    logic [7:0]  exc;
    logic [5:0]  plen;
    logic        reply;
    logic [4:0]  r;
    logic [31:0] w;
    logic [15:0] bc16;
    int          j;
    exc      = 8'h00;
    plen     = SHORT_PDU;
    reply    = 1'b0;
    r        = 5'h00;
    w        = 32'h00000000;
    bc16     = 16'h0000;
    j        = 0;
    range_ok = 1'b0;
    next_st  = st;
    next_st.rsp_v = 1'b0;
    next_st.rsp_l = 1'b0;
    // pins pass three flops; a bit moves once stages two and three agree
    next_st.s1   = din_pin;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.dstb = (~(st.s2 ^ st.s3) & st.s2) | ((st.s2 ^ st.s3) & st.dstb);
    if (st.tv && tx_ready) begin
      next_st.tv = 1'b0;
    end
    case (st.st)
      S_IDLE: begin
        if (master_mode) begin
          // replies from the remote slave go straight out, one byte per cycle
          if (rx_valid && rx_port == TCP_PORT) begin
            next_st.rsp_v = 1'b1;
            next_st.rsp_b = rx_data;
            next_st.rsp_l = rx_last;
          end
          if (packet_build_command) begin
            if (cmd_fc == FC_RAW) begin
              next_st.st = S_RAW; // see [R5]
            end else begin
              // header and request built in one go, then streamed
              next_st.txb[0] = st.tid[15:8];
              next_st.txb[1] = st.tid[7:0];
              next_st.txb[2] = PROTO_ID[15:8];
              next_st.txb[3] = PROTO_ID[7:0];
              next_st.txb[4] = 8'h00;
              next_st.txb[OFS_UNIT] = cmd_unit;
              next_st.txb[OFS_FC] = cmd_fc;
              next_st.txb[8] = cmd_addr[15:8];
              next_st.txb[9] = cmd_addr[7:0];
              next_st.txb[10] = cmd_qty[15:8];
              next_st.txb[11] = cmd_qty[7:0];
              plen = ECHO_PDU;
              case (cmd_fc) // see [R4]
                FC_FORCE_ONE: begin
                  next_st.txb[10] = cmd_value[0] ? COIL_ON[15:8] : COIL_OFF[15:8];
                  next_st.txb[11] = 8'h00;
                end
                FC_PRESET_ONE: begin
                  next_st.txb[10] = cmd_value[15:8];
                  next_st.txb[11] = cmd_value[7:0];
                end
                FC_READ_EXC: plen = 6'h01;
                FC_FORCE_MULT: begin
                  bc16 = (cmd_qty > COIL_MAX_QTY) ? 16'h0003 :
                         (cmd_qty >> 3) + ((cmd_qty[2:0] != 3'h0) ? 16'h0001 : 16'h0000);
                  next_st.txb[12] = bc16[7:0]; // see [R10]
                  next_st.txb[13] = cmd_value[7:0]; // see [R13]
                  next_st.txb[14] = cmd_value[15:8];
                  next_st.txb[15] = cmd_value[23:16];
                  plen = 6'h06 + bc16[5:0];
                end
                FC_PRESET_MULT: begin
                  // one float: high word in the first register
                  bc16 = (cmd_qty > 16'(MAX_RAW_WORDS)) ? 16'(MAX_RAW_WORDS) : cmd_qty;
                  next_st.txb[10] = 8'h00;
                  next_st.txb[11] = bc16[7:0];
                  next_st.txb[12] = {bc16[6:0], 1'b0};
                  next_st.txb[13] = cmd_value[31:24]; // see [R14]
                  next_st.txb[14] = cmd_value[23:16];
                  next_st.txb[15] = cmd_value[15:8];
                  next_st.txb[16] = cmd_value[7:0];
                  plen = 6'h06 + {bc16[4:0], 1'b0};
                end
                default: plen = ECHO_PDU;
              endcase
              next_st.txb[OFS_LEN_LO] = {2'b00, plen} + 8'h01;
              next_st.tx_len = 6'(OFS_FC) + plen;
              next_st.tid = st.tid + 16'h0001;
              next_st.idx = 6'h00;
              next_st.st = S_TX;
            end
          end
        end else if (rx_valid) begin
          next_st.rxb[0] = rx_data;
          next_st.rx_cnt = 6'h01;
          next_st.drop = (rx_port != TCP_PORT); // see [R2]
          next_st.st = rx_last ? S_IDLE : S_RX;
        end
      end
      S_RX: begin
        if (rx_valid) begin
          if (st.rx_cnt < 6'(BUF_DEPTH)) begin
            next_st.rxb[st.rx_cnt] = rx_data; // see [R1]
            next_st.rx_cnt = st.rx_cnt + 6'h01;
          end
          if (rx_last) begin
            next_st.st = S_EXEC;
          end
        end
      end
      S_EXEC: begin
        next_st.st = S_IDLE;
        if (!st.drop && st.rx_cnt >= MIN_FRAME &&
            {st.rxb[2], st.rxb[3]} == PROTO_ID) begin
          reply = 1'b1;
          next_st.txb[OFS_FC] = fc;
          case (fc) // see [R3] see [R16]
            FC_READ_COILS, FC_READ_INPUTS: begin
              range_ok = addr <= COIL_MAX_ADDR && qty != 16'h0000 &&
                         qty <= COIL_MAX_QTY; // see [R8] see [R15]
              next_st.txb[OFS_BC] = {6'h00, pk.count}; // see [R9]
              next_st.txb[9] = pk.packed_bits[7:0];
              next_st.txb[10] = pk.packed_bits[15:8];
              next_st.txb[11] = pk.packed_bits[23:16];
              plen = SHORT_PDU + {4'h0, pk.count};
              exc = EXC_ILL_ADDR;
            end
            FC_READ_HOLD, FC_READ_INREG: begin
              range_ok = qty != 16'h0000 && qty <= REG_MAX_QTY &&
                         ({1'b0, addr} + {1'b0, qty}) <= 17'(REG_MAX_QTY);
              next_st.txb[OFS_BC] = {qty[6:0], 1'b0};
              for (int k = 0; k < 16; k++) begin
                r = addr[4:0] + 5'(k);
                w = rd_src[r[3:1]];
                if (16'(k) < qty) begin
                  next_st.txb[9+2*k] = r[0] ? w[15:8] : w[31:24]; // see [R14]
                  next_st.txb[10+2*k] = r[0] ? w[7:0] : w[23:16];
                end
              end
              plen = SHORT_PDU + {qty[4:0], 1'b0};
              exc = EXC_ILL_ADDR;
            end
            FC_FORCE_ONE: begin
              range_ok = addr <= COIL_MAX_ADDR && (qty == COIL_ON || qty == COIL_OFF);
              if (range_ok) begin
                next_st.dout[addr[4:0]] = (qty == COIL_ON); // see [R12]
              end
              exc = (addr <= COIL_MAX_ADDR) ? EXC_ILL_VAL : EXC_ILL_ADDR;
            end
            FC_PRESET_ONE: begin
              // register 0 holds outputs 15-0, register 1 outputs 23-16
              range_ok = addr <= WORD_MAX_ADDR;
              if (range_ok && addr[0]) begin
                next_st.dout[23:16] = qty[7:0];
              end else if (range_ok) begin
                next_st.dout[15:0] = qty;
              end
              exc = EXC_ILL_ADDR;
            end
            FC_READ_EXC: begin
              range_ok = 1'b1;
              next_st.txb[OFS_BC] = st.dout[7:0];
            end
            FC_FORCE_MULT: begin
              range_ok = addr <= COIL_MAX_ADDR && qty != 16'h0000 &&
                         qty <= COIL_MAX_QTY && st.rxb[12] == {6'h00, pk.count};
              for (int i = 0; i < NUM_DIO; i++) begin
                j = int'(addr[4:0]) + i;
                if (range_ok && 16'(i) < qty && j < NUM_DIO) begin
                  next_st.dout[j] = st.rxb[OFS_WDATA + i/8][i%8]; // see [R13] see [R17]
                end
              end
              exc = (addr <= COIL_MAX_ADDR) ? EXC_ILL_VAL : EXC_ILL_ADDR;
            end
            FC_PRESET_MULT: begin
              range_ok = qty != 16'h0000 && qty <= REG_MAX_QTY &&
                         ({1'b0, addr} + {1'b0, qty}) <= 17'(REG_MAX_QTY) &&
                         st.rxb[12] == {qty[6:0], 1'b0};
              for (int k = 0; k < 16; k++) begin
                r = addr[4:0] + 5'(k);
                if (range_ok && 16'(k) < qty && r[0]) begin
                  next_st.aout[r[3:1]][15:0] = {st.rxb[13+2*k], st.rxb[14+2*k]};
                end else if (range_ok && 16'(k) < qty) begin
                  next_st.aout[r[3:1]][31:16] = {st.rxb[13+2*k], st.rxb[14+2*k]};
                end
              end
              exc = EXC_ILL_ADDR;
            end
            default: exc = EXC_ILL_FUNC;
          endcase
          if (fc == FC_FORCE_ONE || fc == FC_PRESET_ONE ||
              fc == FC_FORCE_MULT || fc == FC_PRESET_MULT) begin
            for (int b = 8; b < 12; b++) begin
              next_st.txb[b] = st.rxb[b];
            end
            plen = ECHO_PDU;
          end
          if (!range_ok) begin
            next_st.txb[OFS_FC] = fc | EXC_FLAG; // see [R17]
            next_st.txb[OFS_BC] = exc;
            plen = SHORT_PDU;
          end
        end
        if (reply) begin
          for (int b = 0; b < OFS_FC; b++) begin
            next_st.txb[b] = st.rxb[b];
          end
          next_st.txb[4] = 8'h00;
          next_st.txb[OFS_LEN_LO] = {2'b00, plen} + 8'h01;
          next_st.tx_len = 6'(OFS_FC) + plen;
          next_st.idx = 6'h00;
          next_st.st = S_TX;
        end
      end
      S_TX: begin
        if (!next_st.tv) begin
          if (st.idx < st.tx_len) begin
            next_st.tbyte = st.txb[st.idx];
            next_st.tlast = (st.idx == st.tx_len - 6'h01);
            next_st.tv = 1'b1;
            next_st.idx = st.idx + 6'h01;
          end else begin
            next_st.st = S_IDLE;
          end
        end
      end
      S_RAW: begin
        // one holding byte: half rate, but no extra buffer
        if (!st.tv && raw_valid) begin
          next_st.tbyte = raw_data; // see [R5]
          next_st.tlast = raw_last;
          next_st.tv = 1'b1;
          if (raw_last) begin
            next_st.tx_len = 6'h00;
            next_st.idx = 6'h00;
            next_st.st = S_TX;
          end
        end
      end
      default: next_st.st = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st      <= '0;
      st.st   <= S_IDLE;
      st.tid  <= TID_RST;
      st.dout <= DOUT_RST;
      st.aout <= {NUM_AN{AOUT_RST}};
    end else begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_exec_ok(logic [7:0] code);
    st.st == S_EXEC && !st.drop && st.rx_cnt >= MIN_FRAME && fc == code && range_ok;
  endsequence
  sequence s_exec_bad;
    st.st == S_EXEC && !st.drop && st.rx_cnt >= MIN_FRAME && !range_ok &&
    {st.rxb[2], st.rxb[3]} == PROTO_ID;
  endsequence

  AST_PORT: assert property (@(posedge mclk) disable iff (rst) // see [R2]
    tx_port == 16'h01F6) else $error("tx port is not 502");
  AST_RAW_PASS: assert property (@(posedge mclk) disable iff (rst) // see [R5]
    raw_valid && raw_ready |=> tx_valid && tx_data == $past(raw_data))
    else $error("raw byte not passed unchanged");
  AST_FC1_HEAD: assert property (@(posedge mclk) disable iff (rst) // see [R9]
    s_exec_ok(FC_READ_COILS) |=> st.txb[OFS_FC] == 8'h01 &&
    st.txb[OFS_BC] == {6'h00, $past(pk.count)}) else $error("read coils header wrong");
  AST_COUNT: assert property (@(posedge mclk) disable iff (rst) // see [R10]
    pk.qty != 5'h00 && pk.qty <= 5'h18 |-> 3'(pk.count) == 3'((6'(pk.qty) + 6'h07) >> 3))
    else $error("byte count not rounded up");
  AST_LSB: assert property (@(posedge mclk) disable iff (rst) // see [R11]
    pk.qty != 5'h00 && pk.start < 5'h18 |-> pk.packed_bits[0] == pk.src[pk.start])
    else $error("first status bit is not the start coil");
  AST_NO_WRITE: assert property (@(posedge mclk) disable iff (rst) // see [R17]
    s_exec_bad |=> $stable(st.dout) && $stable(st.aout) ##1 tx_valid)
    else $error("rejected request changed outputs or gave no answer");
  AST_QUIET_OUT: assert property (@(posedge mclk) disable iff (rst) // see [R16]
    st.st != S_EXEC |=> $stable(dout)) else $error("outputs moved outside decode");
  AST_SWAP: assert property (@(posedge mclk) disable iff (rst) // see [R6]
    s_exec_ok(FC_READ_HOLD) ##0 (addr == 16'h0000) |=> st.txb[9] ==
    ($past(analog_code_swap_setting) ? $past(st.aout[0][31:24]) : $past(ain[31:24])))
    else $error("code 3 source wrong for swap setting");
  AST_FC15: assert property (@(posedge mclk) disable iff (rst) // see [R13]
    s_exec_ok(FC_FORCE_MULT) ##0 (addr == 16'h0000 && qty >= 16'h0008) |=>
    dout[7:0] == $past(st.rxb[OFS_WDATA])) else $error("first byte not outputs 7-0");
  AST_EXEC_TX: assert property (@(posedge mclk) disable iff (rst) // see [R1]
    s_exec_ok(FC_READ_EXC) |=> st.st == S_TX ##1 tx_valid)
    else $error("answer did not start");
endmodule
`default_nettype wire

//--- tb/modbus_master_model.sv
// Purpose: remote modbus master, sends whole frames and takes the answer stream
// Assumes: bytes change just after a falling edge and stay until rx_ready is sampled
// Notes:   random back-pressure on the answer, released data is inverted
`timescale 1ns/1ps
`default_nettype none
module modbus_master_model (
  // clock
  input  wire logic       mclk,
  // request stream into the device
  output logic            rx_valid,
  output logic [7:0]      rx_data,
  output logic            rx_last,
  input  wire logic       rx_ready,
  // answer stream from the device
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  logic [7:0] got[$];
  logic       done;
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'hA5;
    rx_last  = 1'b0;
    tx_ready = 1'b0;
    done     = 1'b0;
  end
  // stalls about one cycle in four, so held answer bytes get exercised
  always @(negedge mclk) tx_ready <= ($urandom % 4) != 0;
  // collect the answer bytes taken
  always @(posedge mclk) begin
    if (tx_valid && tx_ready) begin
      got.push_back(tx_data);
      if (tx_last) done <= 1'b1;
    end
  end
  // one frame, each byte held until taken; the port is set by the bench
  task automatic send(input logic [7:0] f[$]);
    got.delete();
    done = 1'b0;
    foreach (f[i]) begin
      @(negedge mclk);
      rx_valid = 1'b1;
      rx_data  = f[i];
      rx_last  = (i == f.size() - 1);
      @(posedge mclk iff rx_ready);
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_last  = 1'b0;
    rx_data  = ~rx_data; // no stale byte after release
  endtask
endmodule
`default_nettype wire

//--- tb/test_modbus_tcp_coil_responder.sv
// Purpose: slave frame checks of the coil responder
// Assumes: slave role only; master inputs stay idle
// Notes:   expected answers built inline or by the bench functions below
`timescale 1ns/1ps
`default_nettype none
module test_modbus_tcp_coil_responder;
  import modbus_pkg::*;
  logic mclk = 0, rst = 1, rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready, swp;
  logic [7:0] rx_data, tx_data, zb = 8'h00, fcode;
  logic [31:0] aw;
  logic [15:0] tx_port, rx_port = TCP_PORT, zw = 16'h0000;
  logic [23:0] din_pin = 24'h000000, dout, dset;
  logic [255:0] ain = '0;
  logic [7:0] fr[$], ex[$];
  int fails = 0, tests_run = 0, cyc = 0, st, qt;
  initial forever #2 mclk = ~mclk;
  modbus_tcp_coil_responder dut (.mclk, .rst, .master_mode(1'b0),
    .analog_code_swap_setting(swp), .rx_valid, .rx_data, .rx_last, .rx_port, .rx_ready,
    .tx_valid, .tx_data, .tx_last, .tx_port, .tx_ready, .packet_build_command(1'b0),
    .cmd_fc(zb), .cmd_unit(zb), .cmd_addr(zw), .cmd_qty(zw), .cmd_value(32'h00000000),
    .cmd_ready(), .raw_valid(1'b0), .raw_data(zb), .raw_last(1'b0), .raw_ready(),
    .rsp_valid(), .rsp_data(), .rsp_last(), .din_pin, .dout, .ain, .aout());
  modbus_master_model p (.mclk, .rx_valid, .rx_data, .rx_last, .rx_ready, .tx_valid,
    .tx_data, .tx_last, .tx_ready);
  // a hung frame must not stall the run forever
  always @(posedge mclk) if (++cyc == 20000) begin fails++; end_sim(); end
  task automatic end_sim();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic void req(input logic [7:0] fc, input logic [15:0] a, q);
    fr = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h06, 8'h01, fc, a[15:8], a[7:0], q[15:8], q[7:0]};
  endfunction
  // read answer: byte count rounds up, bit 0 of byte 0 is the start coil
  function automatic void exp_rd(input logic [7:0] fc, input logic [23:0] s, input int a, q);
    int bc = q / 8 + ((q % 8) != 0);
    logic [23:0] w = (s >> a) & 24'((25'h1 << q) - 1);
    ex = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'(bc + 3), 8'h01, fc, 8'(bc)};
    for (int i = 0; i < bc; i++) ex.push_back(w[8*i+:8]);
  endfunction
  task automatic chk();
    int j = 0;
    p.send(fr);
    for (int i = 0; i < 400 && p.done !== 1'b1; i++) @(posedge mclk);
    while (j < ex.size() && j < p.got.size() && p.got[j] === ex[j]) j++;
    tests_run++;
    if (j != ex.size() || p.got.size() != ex.size() || p.done !== (ex.size() != 0)) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, j < p.got.size() ? p.got[j] : 8'hXX, j < ex.size() ? ex[j] : 8'hXX);
    end
  endtask
  initial begin
    void'($urandom(80199));
    repeat (20) @(negedge mclk);
    rst = 0;
    for (int n = 0; n < 30; n++) begin
      @(negedge mclk);
      // code 7 reads outputs 7-0; twice a frame comes on another port and is dropped
      rx_port = (n < 2) ? 16'h01F7 : TCP_PORT;
      req(FC_READ_EXC, zw, zw);
      ex = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, FC_READ_EXC, dset[7:0]};
      if (n < 2) ex.delete();
      chk();
      @(negedge mclk);
      rx_port = TCP_PORT;
      dset = $urandom;
      din_pin = $urandom;
      ain = {8{$urandom}};
      swp = $urandom;
      // write all outputs, answer echoes the request header
      req(FC_FORCE_MULT, 16'h0000, 16'h0018);
      ex = fr;
      fr.push_back(8'h03);
      for (int i = 0; i < 3; i++) fr.push_back(dset[8*i+:8]);
      chk();
      tests_run++;
      if (dout !== dset) begin fails++; $display("[ERR] %0t got %h exp %h", $time, dout, dset); end
      st = n == 0 ? 0 : n == 1 ? 23 : $urandom % 24;
      qt = n == 0 ? 24 : n == 1 ? 1 : 1 + $urandom % 24;
      req(FC_READ_COILS, 16'(st), 16'(qt));
      exp_rd(FC_READ_COILS, dset, st, qt);
      chk();
      req(FC_READ_INPUTS, 16'(st), 16'(qt));
      exp_rd(FC_READ_INPUTS, din_pin, st, qt);
      chk();
      // code 3 or 4 at register 0: inputs or outputs, exchanged by the swap setting
      fcode = n[0] ? FC_READ_HOLD : FC_READ_INREG;
      aw = ((fcode == FC_READ_HOLD) != swp) ? ain[31:0] : AOUT_RST;
      req(fcode, zw, 16'h0002);
      ex = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h07, 8'h01, fcode, 8'h04, aw[31:24],
        aw[23:16], aw[15:8], aw[7:0]};
      chk();
      // start beyond the last coil: refused, outputs kept
      req(FC_FORCE_MULT, 16'(16'h0018 + n), 16'h0008);
      fr.push_back(8'h01);
      fr.push_back(~dset[7:0]);
      ex = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h8F, EXC_ILL_ADDR};
      chk();
      tests_run++;
      if (dout !== dset || tx_port !== TCP_PORT) begin fails++; $display("[ERR] %0t got %h exp %h", $time, dout, dset); end
    end
    end_sim();
  end
endmodule
`default_nettype wire
